// ==== core/pwm_channel.sv ====
// One PWM channel: derives period and high time, then counts them out
`timescale 1ns/1ps
module pwm_channel (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cfg_load, // Recompute from cfg
	input wire pwm_ctl_pkg::pwm_cfg_t cfg,
	input wire logic run, // Output allowed
	output logic busy,
	output logic pwm_out
);

	pwm_ctl_pkg::chan_state_t s_q; // All channel state
	pwm_ctl_pkg::chan_state_t s_d;
	logic [pwm_ctl_pkg::DIV_W:0] sh; // Partial remainder
	logic [pwm_ctl_pkg::DIV_W-1:0] q; // Partial quotient
	logic [pwm_ctl_pkg::CNT_W-1:0] hq; // Raw quotient: period first, then high time

	////////////////////////////////////////////////////////////////////////////
	// Serial restoring divider, then period counter
	// One divider step per clock keeps area small; a reload takes 80 cycles
	always_comb begin
		s_d = s_q;
		sh = {s_q.rem[pwm_ctl_pkg::DIV_W-1:0], s_q.quo[pwm_ctl_pkg::DIV_W-1]};
		q = {s_q.quo[pwm_ctl_pkg::DIV_W-2:0], 1'b0};
		hq = q[pwm_ctl_pkg::CNT_W-1:0];
		if (sh >= {1'b0, s_q.den}) begin
			sh = sh - {1'b0, s_q.den};
			q[0] = 1'b1;
		end
		hq = q[pwm_ctl_pkg::CNT_W-1:0];
		case (s_q.ph)
			pwm_ctl_pkg::PH_IDLE: begin
				s_d.step = 6'h00; // Nothing to divide
			end
			pwm_ctl_pkg::PH_PER, pwm_ctl_pkg::PH_HIGH: begin
				s_d.rem = sh;
				s_d.quo = q;
				s_d.step = s_q.step + 6'h01;
				if (s_q.step == pwm_ctl_pkg::DIV_LAST && s_q.ph == pwm_ctl_pkg::PH_PER) begin
					// Period is whole clock cycles, rounded down: rate at or above the request
					s_d.period = hq;
					s_d.rem = '0;
					s_d.quo = pwm_ctl_pkg::DIV_W'(hq) * pwm_ctl_pkg::DIV_W'(s_q.duty);
					s_d.den = pwm_ctl_pkg::DIV_W'(pwm_ctl_pkg::DUTY_FULL);
					s_d.step = 6'h00;
					s_d.ph = pwm_ctl_pkg::PH_HIGH;
				end else if (s_q.step == pwm_ctl_pkg::DIV_LAST) begin
					// Clamp so the output always toggles; coarse at high rates
					if (hq == '0) begin
						s_d.high = pwm_ctl_pkg::CNT_W'(1);
					end else if (hq >= s_q.period) begin
						s_d.high = s_q.period - pwm_ctl_pkg::CNT_W'(1);
					end else begin
						s_d.high = hq;
					end
					s_d.ph = pwm_ctl_pkg::PH_IDLE;
				end
			end
			default: begin
				s_d.ph = pwm_ctl_pkg::PH_IDLE;
			end
		endcase
		// New settings restart the divider
		if (cfg_load) begin
			s_d.ph = pwm_ctl_pkg::PH_PER;
			s_d.step = 6'h00;
			s_d.rem = '0;
			s_d.quo = pwm_ctl_pkg::DIV_W'(pwm_ctl_pkg::CLK_HZ);
			s_d.den = pwm_ctl_pkg::DIV_W'(cfg.freq);
			s_d.duty = cfg.duty;
		end
		// Output counter, held off while stopped or recomputing
		if (!run || s_q.ph != pwm_ctl_pkg::PH_IDLE) begin
			s_d.cnt = '0;
			s_d.out = 1'b0;
		end else begin
			s_d.cnt = (s_q.cnt >= s_q.period - pwm_ctl_pkg::CNT_W'(1)) ? '0 : s_q.cnt + pwm_ctl_pkg::CNT_W'(1);
			s_d.out = (s_q.cnt < s_q.high);
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = (s_q.ph != pwm_ctl_pkg::PH_IDLE);
	assign pwm_out = s_q.out;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_high_range: assert property (@(posedge core_clk) disable iff (rst)
		$fell(busy) |-> (s_q.high != '0) && (s_q.high < s_q.period))
		else $error("high time outside period");

endmodule

// ==== core/pwm_ctl_pkg.sv ====
// Shared constants and types of the PWM output control block
package pwm_ctl_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_HZ = 32'h0262_5A00; // 40 MHz module clock
	localparam int CLK_PERIOD_NS = 32'h0000_0019; // 25 ns
	localparam int HWD_STEP_NS = 32'h05F5_E100; // 0.1 s watchdog step
	localparam int HWD_STEP_CYC = HWD_STEP_NS / CLK_PERIOD_NS; // Cycles per step
	localparam int HWD_TICK_W = 23; // Holds one step count
	localparam int MWD_LIMIT_CYC = 32'h0000_0800; // Stall cycles before self reset
	localparam int MWD_W = 16;

	////////////////////////////////////////////////////////////////////////////
	// Channels and divider
	localparam int CH_N = 8;
	localparam int CH_W = 3;
	localparam logic [CH_W-1:0] CH_LAST = 3'h7;
	localparam int CNT_W = 26; // Wide enough for a 1 Hz period
	localparam int DIV_W = 40; // Holds period times duty
	localparam logic [5:0] DIV_LAST = 6'h27; // Last of DIV_W steps

	////////////////////////////////////////////////////////////////////////////
	// Frequency and duty limits, duty in tenths of a percent
	localparam logic [18:0] F_FINE_MAX = 19'h003E8; // 1000 Hz
	localparam logic [18:0] F_COARSE_MAX = 19'h02710; // 10000 Hz
	localparam logic [9:0] DUTY_MIN = 10'h001; // 0.1 %
	localparam logic [9:0] DUTY_MAX = 10'h3E7; // 99.9 %
	localparam logic [9:0] DUTY_STEP = 10'h00A; // 1 %
	localparam logic [9:0] DUTY_FULL = 10'h3E8; // 100 %

	////////////////////////////////////////////////////////////////////////////
	// Status codes and reset values
	localparam logic [7:0] STATUS_TRIP = 8'h04;
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] DEF_ADDR = 8'h00;
	localparam logic [5:0] DEF_BAUD = 6'h06; // 9600 bps code

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic [18:0] freq; // Hz
		logic [9:0] duty; // Tenths of a percent
	} pwm_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [5:0] baud;
		logic cksum;
		logic proto; // 0: ASCII command protocol
	} comm_cfg_t;

	localparam comm_cfg_t DEF_COMM = '{addr: DEF_ADDR, baud: DEF_BAUD, cksum: 1'b0, proto: 1'b0};

	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_SET_OUTPUT = 4'h1, // set_output_cmd
		CMD_CLEAR_STATUS = 4'h2, // clear_module_status_cmd
		CMD_SAVE = 4'h3, // save_pwm_config_cmd
		CMD_QUERY_RESET = 4'h4, // query_reset_flag_cmd
		CMD_SET_COMM = 4'h5, // set_comm_settings_cmd
		CMD_SELECT_PROTO = 4'h6, // select_protocol_cmd
		CMD_SET_PWM = 4'h7,
		CMD_READ_CFG = 4'h8
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t kind;
		logic [CH_W-1:0] ch;
		pwm_cfg_t pwm;
		logic [CH_N-1:0] data;
		comm_cfg_t comm;
	} cmd_t;

	typedef enum logic {RSP_OK = 1'b0, RSP_INVALID = 1'b1} resp_code_t;

	typedef struct packed {
		logic valid;
		resp_code_t code;
		logic [15:0] data;
	} resp_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [CH_W-1:0] addr;
		pwm_cfg_t wdata;
	} nvm_req_t;

	typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_LOAD = 2'b01, ST_RUN = 2'b10, ST_SAVE = 2'b11} main_st_t;

	typedef struct packed {
		main_st_t st;
		logic [CH_W-1:0] ch;
		logic init_mode;
		comm_cfg_t comm;
		logic [CH_N-1:0] out;
		logic tripped;
		logic reset_flag;
		logic [HWD_TICK_W-1:0] tick;
		logic [7:0] hwd;
		logic [MWD_W-1:0] mwd;
		logic mwd_reset;
		resp_t resp;
		nvm_req_t nvm;
		logic comm_wr;
		comm_cfg_t comm_wdata;
		logic [CH_N-1:0] ld;
		pwm_cfg_t [CH_N-1:0] cfg;
	} main_state_t;

	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_PER = 2'b01, PH_HIGH = 2'b10} chan_ph_t;

	typedef struct packed {
		chan_ph_t ph;
		logic [5:0] step;
		logic [DIV_W:0] rem;
		logic [DIV_W-1:0] quo;
		logic [DIV_W-1:0] den;
		logic [9:0] duty;
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] high;
		logic [CNT_W-1:0] cnt;
		logic out;
	} chan_state_t;

endpackage

// ==== core/pwm_output_watchdog_control.sv ====
// PWM output control: boot load, save, limits, host and module watchdogs
`timescale 1ns/1ps
// Function
// - Outputs stay off after power-up until started
// - Host watchdog trip stops outputs, status 04
// - Tripped: output command refused, answer invalid
// - Clear command returns status 0, outputs allowed
// - Load channel configs from storage at boot
// - Save command writes all channel configs
// - Up to 1000 Hz: duty 0.1-99.9 %
// - Up to 10000 Hz: duty 1-99 % whole
// - Above 10000 Hz: nearest rate, coarse duty (channel rounds the period down)
// - Default mode: address 00, 9600, no checksum
// - Default mode leaves storage, stored config readable
// - Comm and protocol commands only in default mode
// - Host silence drives outputs to safe state
// - Module watchdog resets a stalled module
// - Reset flag set by power-up and watchdog
// - Reset flag cleared after first query answer
// - Any reset restores power-on output value
// - Host timeout 0-255 in 0.1 s steps
module pwm_output_watchdog_control #(
	parameter int HWD_TICK = pwm_ctl_pkg::HWD_STEP_CYC, // Cycles per 0.1 s
	parameter int MWD_LIMIT = pwm_ctl_pkg::MWD_LIMIT_CYC // Stall cycles
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic init_strap, // Default-settings mode request
	input wire logic cmd_valid,
	input wire pwm_ctl_pkg::cmd_t cmd,
	output logic cmd_ready,
	output pwm_ctl_pkg::resp_t resp,
	input wire logic hwd_enable,
	input wire logic [7:0] hwd_timeout, // Tenths of a second
	input wire pwm_ctl_pkg::comm_cfg_t comm_stored,
	output pwm_ctl_pkg::comm_cfg_t comm_active,
	output logic comm_wr,
	output pwm_ctl_pkg::comm_cfg_t comm_wdata,
	output pwm_ctl_pkg::nvm_req_t nvm,
	input wire logic nvm_ack,
	input wire pwm_ctl_pkg::pwm_cfg_t nvm_rdata,
	output logic [7:0] module_status,
	output logic reset_flag,
	output logic mwd_reset,
	output logic [pwm_ctl_pkg::CH_N-1:0] pwm_out
);

	// Counter end values at register width
	localparam logic [pwm_ctl_pkg::HWD_TICK_W-1:0] TICK_LAST = pwm_ctl_pkg::HWD_TICK_W'(HWD_TICK - 1);
	localparam logic [pwm_ctl_pkg::MWD_W-1:0] MWD_LAST = pwm_ctl_pkg::MWD_W'(MWD_LIMIT - 1);

	pwm_ctl_pkg::main_state_t s_q; // All control state
	pwm_ctl_pkg::main_state_t s_d;
	logic taken; // Command accepted this cycle
	logic trip_evt; // Host timeout this cycle
	logic running; // Channels may drive
	logic [pwm_ctl_pkg::CH_N-1:0] ch_busy;

	////////////////////////////////////////////////////////////////////////////
	// Duty and frequency limits
	// Frequency zero is never a valid request
	function automatic logic pwm_ok(input pwm_ctl_pkg::pwm_cfg_t c);
		logic in_range;
		logic ok;
		in_range = (c.duty >= pwm_ctl_pkg::DUTY_MIN) && (c.duty <= pwm_ctl_pkg::DUTY_MAX);
		ok = 1'b0;
		if (c.freq == 19'h00000) begin
			ok = 1'b0;
		end else if (c.freq <= pwm_ctl_pkg::F_FINE_MAX) begin
			ok = in_range;
		end else if (c.freq <= pwm_ctl_pkg::F_COARSE_MAX) begin
			ok = in_range && ((c.duty % pwm_ctl_pkg::DUTY_STEP) == 10'h000);
		end else begin
			ok = in_range; // Approximated by the channel
		end
		return ok;
	endfunction

	assign cmd_ready = (s_q.st == pwm_ctl_pkg::ST_RUN);
	assign taken = cmd_valid && cmd_ready;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.resp.valid = 1'b0;
		s_d.comm_wr = 1'b0;
		s_d.ld = '0;
		s_d.mwd_reset = 1'b0;
		trip_evt = 1'b0;

		// Host watchdog: any accepted command restarts the timeout
		if (taken) begin
			s_d.tick = '0;
			s_d.hwd = 8'h00;
		end else if (hwd_enable && hwd_timeout != 8'h00 && !s_q.tripped && s_q.st[1]) begin
			if (s_q.tick == TICK_LAST) begin
				s_d.tick = '0;
				s_d.hwd = s_q.hwd + 8'h01;
				trip_evt = (s_q.hwd + 8'h01 >= hwd_timeout);
			end else begin
				s_d.tick = s_q.tick + pwm_ctl_pkg::HWD_TICK_W'(1);
			end
		end
		// Trip forces safe state: every output off
		if (trip_evt) begin
			s_d.tripped = 1'b1;
			s_d.out = '0;
		end

		case (s_q.st)
			// Catch the strap once per boot, after reset release or a module watchdog restart
			pwm_ctl_pkg::ST_BOOT: begin
				s_d.init_mode = init_strap;
				// Defaults override storage, which stays untouched
				s_d.comm = init_strap ? pwm_ctl_pkg::DEF_COMM : comm_stored;
				s_d.ch = '0;
				s_d.nvm.req = 1'b1;
				s_d.nvm.we = 1'b0;
				s_d.nvm.addr = '0;
				s_d.st = pwm_ctl_pkg::ST_LOAD;
			end
			// Read each channel config before any output can run
			pwm_ctl_pkg::ST_LOAD: begin
				if (nvm_ack) begin
					s_d.cfg[s_q.ch] = nvm_rdata;
					s_d.ld[s_q.ch] = 1'b1;
					if (s_q.ch == pwm_ctl_pkg::CH_LAST) begin
						s_d.nvm.req = 1'b0;
						s_d.st = pwm_ctl_pkg::ST_RUN;
					end else begin
						s_d.ch = s_q.ch + 3'h1;
						s_d.nvm.addr = s_q.ch + 3'h1;
					end
				end
			end
			// Write every channel config in turn
			pwm_ctl_pkg::ST_SAVE: begin
				if (nvm_ack) begin
					if (s_q.ch == pwm_ctl_pkg::CH_LAST) begin
						s_d.nvm.req = 1'b0;
						s_d.nvm.we = 1'b0;
						s_d.resp.valid = 1'b1;
						s_d.resp.code = pwm_ctl_pkg::RSP_OK;
						s_d.resp.data = 16'h0000;
						s_d.st = pwm_ctl_pkg::ST_RUN;
					end else begin
						s_d.ch = s_q.ch + 3'h1;
						s_d.nvm.addr = s_q.ch + 3'h1;
						s_d.nvm.wdata = s_q.cfg[s_q.ch + 3'h1];
					end
				end
			end
			// Command handling
			pwm_ctl_pkg::ST_RUN: begin
				if (taken) begin
					s_d.resp.valid = 1'b1;
					s_d.resp.code = pwm_ctl_pkg::RSP_OK;
					s_d.resp.data = 16'h0000;
					case (cmd.kind)
						pwm_ctl_pkg::CMD_SET_OUTPUT: begin
							// Outputs start only on request
							if (s_q.tripped) begin
								s_d.resp.code = pwm_ctl_pkg::RSP_INVALID;
							end else begin
								s_d.out = cmd.data;
							end
						end
						pwm_ctl_pkg::CMD_CLEAR_STATUS: begin
							s_d.tripped = 1'b0;
						end
						pwm_ctl_pkg::CMD_SAVE: begin
							s_d.resp.valid = 1'b0; // Answer when done
							s_d.ch = '0;
							s_d.nvm.req = 1'b1;
							s_d.nvm.we = 1'b1;
							s_d.nvm.addr = '0;
							s_d.nvm.wdata = s_q.cfg[0];
							s_d.st = pwm_ctl_pkg::ST_SAVE;
						end
						pwm_ctl_pkg::CMD_QUERY_RESET: begin
							s_d.resp.data = {15'h0000, s_q.reset_flag};
							s_d.reset_flag = 1'b0;
						end
						pwm_ctl_pkg::CMD_SET_COMM: begin
							if (s_q.init_mode) begin
								s_d.comm_wr = 1'b1;
								s_d.comm_wdata = cmd.comm;
							end else begin
								s_d.resp.code = pwm_ctl_pkg::RSP_INVALID;
							end
						end
						pwm_ctl_pkg::CMD_SELECT_PROTO: begin
							if (s_q.init_mode) begin
								s_d.comm_wr = 1'b1;
								s_d.comm_wdata = comm_stored;
								s_d.comm_wdata.proto = cmd.comm.proto;
							end else begin
								s_d.resp.code = pwm_ctl_pkg::RSP_INVALID;
							end
						end
						pwm_ctl_pkg::CMD_SET_PWM: begin
							if (pwm_ok(cmd.pwm)) begin
								s_d.cfg[cmd.ch] = cmd.pwm;
								s_d.ld[cmd.ch] = 1'b1;
							end else begin
								s_d.resp.code = pwm_ctl_pkg::RSP_INVALID;
							end
						end
						pwm_ctl_pkg::CMD_READ_CFG: begin
							s_d.resp.data = comm_stored;
						end
						default: begin
							s_d.resp.code = pwm_ctl_pkg::RSP_INVALID;
						end
					endcase
				end
			end
			default: begin
				s_d.st = pwm_ctl_pkg::ST_BOOT;
			end
		endcase

		// Module watchdog: storage that never answers means a stalled module
		// Restart clears everything, so outputs return to power-on off
		if ((s_q.st == pwm_ctl_pkg::ST_LOAD || s_q.st == pwm_ctl_pkg::ST_SAVE) && !nvm_ack) begin
			if (s_q.mwd == MWD_LAST) begin
				s_d = '0;
				s_d.reset_flag = 1'b1;
				s_d.mwd_reset = 1'b1;
			end else begin
				s_d.mwd = s_q.mwd + pwm_ctl_pkg::MWD_W'(1);
			end
		end else begin
			s_d.mwd = '0;
		end
	end

	// State register; power-up reset sets the reset flag
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q <= '0; // Outputs to power-on off
			s_q.reset_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels
	// Channels keep counting through a save so outputs do not glitch
	assign running = (s_q.st == pwm_ctl_pkg::ST_RUN || s_q.st == pwm_ctl_pkg::ST_SAVE) && !s_q.tripped;

	for (genvar i = 0; i < pwm_ctl_pkg::CH_N; i++) begin : g_ch
		pwm_channel u_ch (
			.core_clk(core_clk),
			.rst(rst),
			.cfg_load(s_q.ld[i]),
			.cfg(s_q.cfg[i]),
			.run(running && s_q.out[i]),
			.busy(ch_busy[i]),
			.pwm_out(pwm_out[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign resp = s_q.resp;
	assign comm_active = s_q.comm;
	assign comm_wr = s_q.comm_wr;
	assign comm_wdata = s_q.comm_wdata;
	assign nvm = s_q.nvm;
	assign module_status = s_q.tripped ? pwm_ctl_pkg::STATUS_TRIP : pwm_ctl_pkg::STATUS_OK;
	assign reset_flag = s_q.reset_flag;
	assign mwd_reset = s_q.mwd_reset;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_boot_off: assert property (
		(s_q.st == pwm_ctl_pkg::ST_LOAD) |-> (pwm_out == '0) && (s_q.out == '0))
		else $error("output active before configuration loaded");

	chk_trip_safe: assert property (
		trip_evt |=> (module_status == pwm_ctl_pkg::STATUS_TRIP) && (s_q.out == '0) ##1 (pwm_out == '0))
		else $error("trip did not stop outputs");

	chk_refuse_set: assert property (
		taken && cmd.kind == pwm_ctl_pkg::CMD_SET_OUTPUT && s_q.tripped
		|=> resp.valid && resp.code == pwm_ctl_pkg::RSP_INVALID && $stable(s_q.out))
		else $error("output command accepted while tripped");

	chk_clear_status: assert property (
		taken && cmd.kind == pwm_ctl_pkg::CMD_CLEAR_STATUS |=> module_status == pwm_ctl_pkg::STATUS_OK)
		else $error("status not cleared");

	chk_save_start: assert property (
		taken && cmd.kind == pwm_ctl_pkg::CMD_SAVE |=> nvm.req && nvm.we && nvm.addr == '0 && !cmd_ready)
		else $error("save did not start storage write");

	chk_duty_limit: assert property (
		taken && cmd.kind == pwm_ctl_pkg::CMD_SET_PWM
		|=> resp.valid && ((resp.code == pwm_ctl_pkg::RSP_INVALID) == !pwm_ok($past(cmd.pwm))))
		else $error("duty limit answer wrong");

	chk_init_defaults: assert property (
		s_q.init_mode && cmd_ready |-> comm_active == pwm_ctl_pkg::DEF_COMM)
		else $error("default mode settings not applied");

	chk_mode_only: assert property (
		taken && !s_q.init_mode
		&& (cmd.kind == pwm_ctl_pkg::CMD_SET_COMM || cmd.kind == pwm_ctl_pkg::CMD_SELECT_PROTO)
		|=> resp.code == pwm_ctl_pkg::RSP_INVALID && !comm_wr)
		else $error("mode-restricted command accepted");

	chk_flag_once: assert property (
		taken && cmd.kind == pwm_ctl_pkg::CMD_QUERY_RESET
		|=> resp.data[0] == $past(s_q.reset_flag) && !reset_flag)
		else $error("reset flag not reported then cleared");

	chk_mwd_restart: assert property (
		mwd_reset |-> s_q.st == pwm_ctl_pkg::ST_BOOT && reset_flag && s_q.out == '0 ##1 nvm.req)
		else $error("module watchdog restart incomplete");

	cov_trip: cover property (trip_evt);
	cov_save_done: cover property (s_q.st == pwm_ctl_pkg::ST_SAVE ##1 cmd_ready && resp.valid);
	cov_flag_query: cover property (taken && cmd.kind == pwm_ctl_pkg::CMD_QUERY_RESET && s_q.reset_flag);
	cov_clear_trip: cover property (taken && cmd.kind == pwm_ctl_pkg::CMD_CLEAR_STATUS && s_q.tripped);
	cov_reload: cover property ($fell(ch_busy[0]));

endmodule

// ==== testbench/nvm_model.sv ====
// Storage partner holding one config image per channel
`timescale 1ns/1ps
module nvm_model #(
	parameter int LAT = 2 // Cycles before each ack
) (
	input wire logic core_clk,
	input wire logic stall, // Never answers while high
	input wire pwm_ctl_pkg::nvm_req_t nvm,
	output logic nvm_ack,
	output pwm_ctl_pkg::pwm_cfg_t nvm_rdata
);
	pwm_ctl_pkg::pwm_cfg_t mem [8]; // Stored images
	pwm_ctl_pkg::pwm_cfg_t rd_q; // Last read
	int wait_q = 0;
	initial begin
		nvm_ack = 1'b0;
		foreach (mem[i]) mem[i] = '{freq: 19'h00064, duty: 10'h1F4};
	end
	// Read data is only valid with ack, so it is scrambled otherwise
	assign nvm_rdata = nvm_ack ? rd_q : ~rd_q;
	// One ack per request after LAT cycles
	always @(posedge core_clk) begin
		nvm_ack <= 1'b0;
		if (nvm.req && !nvm_ack && !stall) begin
			wait_q <= wait_q + 1;
			if (wait_q >= LAT) begin
				wait_q <= 0;
				nvm_ack <= 1'b1;
				rd_q <= mem[nvm.addr];
				if (nvm.we) mem[nvm.addr] <= nvm.wdata;
			end
		end
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the PWM output control block
`timescale 1ns/1ps
module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic init_strap = 1'b0;
	logic cmd_valid = 1'b0;
	logic stall = 1'b0; // Storage stops answering
	pwm_ctl_pkg::cmd_t cmd = '0;
	logic hwd_enable = 1'b0;
	logic [7:0] hwd_timeout = 8'h00;
	pwm_ctl_pkg::comm_cfg_t comm_stored = '{addr: 8'h12, baud: 6'h08, cksum: 1'b1, proto: 1'b0};
	pwm_ctl_pkg::comm_cfg_t comm_active, comm_wdata;
	pwm_ctl_pkg::resp_t resp, r;
	pwm_ctl_pkg::nvm_req_t nvm;
	pwm_ctl_pkg::pwm_cfg_t nvm_rdata;
	logic cmd_ready, comm_wr, nvm_ack, reset_flag, mwd_reset, wr_seen;
	logic [7:0] module_status, pwm_out;
	int errors = 0;
	int cmp_count = 0;
	int reads = 0; // Read acks since reset

	pwm_output_watchdog_control #(.HWD_TICK(10), .MWD_LIMIT(16)) u_dut (.core_clk(core_clk), .rst(rst),
		.init_strap(init_strap), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp),
		.hwd_enable(hwd_enable), .hwd_timeout(hwd_timeout), .comm_stored(comm_stored),
		.comm_active(comm_active), .comm_wr(comm_wr), .comm_wdata(comm_wdata), .nvm(nvm), .nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata), .module_status(module_status), .reset_flag(reset_flag),
		.mwd_reset(mwd_reset), .pwm_out(pwm_out));
	nvm_model u_nvm (.core_clk(core_clk), .stall(stall), .nvm(nvm), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));

	always #12.5 core_clk = ~core_clk;
	// A module watchdog restart reloads every channel, so the count starts afresh
	always @(posedge core_clk) reads <= (rst || mwd_reset) ? 0 : reads + (nvm.req && !nvm.we && nvm_ack);

	////////////////////////////////////////
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Poll after each edge so that edge's updates have landed
	task automatic edge_poll(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask
	task automatic wait_ready();
		int n = 0;
		while (cmd_ready !== 1'b1 && n < 500) begin
			edge_poll(1);
			n++;
		end
		check("ready", cmd_ready, 1'b1);
		check("boot reads", reads, 8);
	endtask
	task automatic do_reset(input logic strap);
		@(posedge core_clk);
		rst <= 1'b1;
		init_strap <= strap;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		check("flag after reset", reset_flag, 1'b1);
		check("outputs after reset", pwm_out, 8'h00);
		wait_ready();
	endtask
	// Request held until taken; answer picked up within a bounded wait
	task automatic send(input pwm_ctl_pkg::cmd_kind_t k, input logic [2:0] ch, input logic [18:0] f,
		input logic [9:0] d, input logic [7:0] data);
		int n = 0;
		@(posedge core_clk);
		cmd <= '{kind: k, ch: ch, pwm: '{freq: f, duty: d}, data: data, comm: comm_stored};
		cmd_valid <= 1'b1;
		@(posedge core_clk);
		while (!cmd_ready && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		cmd_valid <= 1'b0;
		n = 0;
		#1;
		while (resp.valid !== 1'b1 && n < 500) begin
			edge_poll(1);
			n++;
		end
		r = resp;
		wr_seen = comm_wr;
		check("answer", resp.valid, 1'b1);
	endtask
	task automatic measure(input logic [2:0] ch, input int hi, input int per);
		int n = 0;
		int h = 0;
		int l = 0;
		while (pwm_out[ch] !== 1'b0 && n < 9000) begin
			edge_poll(1);
			n++;
		end
		while (pwm_out[ch] !== 1'b1 && n < 9000) begin
			edge_poll(1);
			n++;
		end
		while (pwm_out[ch] === 1'b1 && h < 9000) begin
			edge_poll(1);
			h++;
		end
		while (pwm_out[ch] === 1'b0 && l < 9000) begin
			edge_poll(1);
			l++;
		end
		check("high cycles", h, hi);
		check("period cycles", h + l, per);
	endtask

	////////////////////////////////////////
	task automatic t_boot();
		do_reset(1'b0);
		check("stored comm", comm_active, comm_stored);
		edge_poll(200);
		check("idle outputs", pwm_out, 8'h00);
		send(pwm_ctl_pkg::CMD_QUERY_RESET, 3'h0, 19'h0, 10'h0, 8'h00);
		check("first query", r.data[0], 1'b1);
		send(pwm_ctl_pkg::CMD_QUERY_RESET, 3'h0, 19'h0, 10'h0, 8'h00);
		check("second query", r.data[0], 1'b0);
		send(pwm_ctl_pkg::CMD_NONE, 3'h0, 19'h0, 10'h0, 8'h00);
		check("unknown command", r.code, pwm_ctl_pkg::RSP_INVALID);
		$display("test boot done");
	endtask
	// Duty boundaries of the fine and coarse bands
	task automatic t_limits();
		logic [18:0] fq[8] = '{19'h003E8, 19'h003E8, 19'h003E8, 19'h003E9, 19'h003E9, 19'h02710, 19'h02710, 19'h0};
		logic [9:0] dt[8] = '{10'h001, 10'h3E7, 10'h000, 10'h001, 10'h00A, 10'h3DE, 10'h3E3, 10'h1F4};
		logic cd[8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		foreach (fq[i]) begin
			send(pwm_ctl_pkg::CMD_SET_PWM, 3'h1, fq[i], dt[i], 8'h00);
			check("limit code", r.code, cd[i]);
		end
		send(pwm_ctl_pkg::CMD_SET_PWM, 3'h1, 19'h7A120, 10'h1F4, 8'h00);
		check("fast accept", r.code, pwm_ctl_pkg::RSP_OK);
		send(pwm_ctl_pkg::CMD_SET_PWM, 3'h2, 19'h02710, 10'h0FA, 8'h00);
		send(pwm_ctl_pkg::CMD_SET_OUTPUT, 3'h0, 19'h0, 10'h0, 8'h06);
		measure(3'h1, 40, 80);
		measure(3'h2, 1000, 4000);
		check("idle channel", pwm_out[0], 1'b0);
		$display("test limits done");
	endtask
	task automatic t_trip();
		int n = 0;
		hwd_timeout <= 8'h02;
		hwd_enable <= 1'b1;
		send(pwm_ctl_pkg::CMD_QUERY_RESET, 3'h0, 19'h0, 10'h0, 8'h00);
		edge_poll(15);
		check("early trip", module_status, 8'h00);
		while (module_status !== 8'h04 && n < 40) begin
			edge_poll(1);
			n++;
		end
		check("trip status", module_status, pwm_ctl_pkg::STATUS_TRIP);
		check("trip cycles", n, 5);
		edge_poll(3);
		check("safe outputs", pwm_out, 8'h00);
		hwd_enable <= 1'b0;
		send(pwm_ctl_pkg::CMD_SET_OUTPUT, 3'h0, 19'h0, 10'h0, 8'h02);
		check("refused output", r.code, pwm_ctl_pkg::RSP_INVALID);
		edge_poll(150);
		check("no restart", pwm_out, 8'h00);
		send(pwm_ctl_pkg::CMD_CLEAR_STATUS, 3'h0, 19'h0, 10'h0, 8'h00);
		check("cleared", module_status, 8'h00);
		send(pwm_ctl_pkg::CMD_SET_OUTPUT, 3'h0, 19'h0, 10'h0, 8'h02);
		check("output again", r.code, pwm_ctl_pkg::RSP_OK);
		measure(3'h1, 40, 80);
		hwd_timeout <= 8'h00;
		hwd_enable <= 1'b1;
		edge_poll(300);
		check("zero timeout", module_status, 8'h00);
		hwd_enable <= 1'b0;
		$display("test trip done");
	endtask
	// Host saves after changing a channel
	task automatic t_save();
		send(pwm_ctl_pkg::CMD_SET_PWM, 3'h3, 19'h7A120, 10'h1F4, 8'h00);
		send(pwm_ctl_pkg::CMD_SAVE, 3'h0, 19'h0, 10'h0, 8'h00);
		check("save code", r.code, pwm_ctl_pkg::RSP_OK);
		check("saved image", u_nvm.mem[3], {19'h7A120, 10'h1F4});
		do_reset(1'b0);
		send(pwm_ctl_pkg::CMD_SET_OUTPUT, 3'h0, 19'h0, 10'h0, 8'h08);
		measure(3'h3, 40, 80);
		$display("test save done");
	endtask
	task automatic t_init();
		do_reset(1'b1);
		check("default comm", comm_active, pwm_ctl_pkg::DEF_COMM);
		send(pwm_ctl_pkg::CMD_READ_CFG, 3'h0, 19'h0, 10'h0, 8'h00);
		check("stored readable", r.data, comm_stored);
		send(pwm_ctl_pkg::CMD_SET_COMM, 3'h0, 19'h0, 10'h0, 8'h00);
		check("comm in default", {r.code, wr_seen}, 2'b01);
		check("comm data", comm_wdata, comm_stored);
		send(pwm_ctl_pkg::CMD_SELECT_PROTO, 3'h0, 19'h0, 10'h0, 8'h00);
		check("proto in default", r.code, pwm_ctl_pkg::RSP_OK);
		check("still default", comm_active, pwm_ctl_pkg::DEF_COMM);
		do_reset(1'b0);
		send(pwm_ctl_pkg::CMD_SET_COMM, 3'h0, 19'h0, 10'h0, 8'h00);
		check("comm refused", {r.code, wr_seen}, 2'b10);
		send(pwm_ctl_pkg::CMD_SELECT_PROTO, 3'h0, 19'h0, 10'h0, 8'h00);
		check("proto refused", r.code, pwm_ctl_pkg::RSP_INVALID);
		$display("test init done");
	endtask
	// Storage stalls from the start of a save, so the module watchdog must restart
	task automatic t_mwd();
		int n = 0;
		send(pwm_ctl_pkg::CMD_QUERY_RESET, 3'h0, 19'h0, 10'h0, 8'h00);
		stall <= 1'b1;
		cmd.kind <= pwm_ctl_pkg::CMD_SAVE;
		cmd_valid <= 1'b1;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		while (mwd_reset !== 1'b1 && n < 100) begin
			edge_poll(1);
			n++;
		end
		check("self reset", mwd_reset, 1'b1);
		check("flag by watchdog", reset_flag, 1'b1);
		check("outputs restored", pwm_out, 8'h00);
		stall <= 1'b0;
		wait_ready();
		send(pwm_ctl_pkg::CMD_QUERY_RESET, 3'h0, 19'h0, 10'h0, 8'h00);
		check("query after restart", r.data[0], 1'b1);
		$display("test watchdog done");
	endtask

	initial begin
		t_boot();
		t_limits();
		t_trip();
		t_save();
		t_init();
		t_mwd();
		complete_run();
	end
	// Hang guard well beyond the expected run length
	initial begin
		repeat (80000) @(posedge core_clk);
		errors++;
		complete_run();
	end
endmodule
